/* File: design/lda_pkg.sv */
// Package with address constants and carrier types for the LED driver address decoder
package lda_pkg;
   localparam logic [6:0] BROADCAST_ADDR_RESET = 7'h70;
   localparam logic [6:0] SUBGROUP_ONE_RESET = 7'h71;
   localparam logic [6:0] SUBGROUP_TWO_RESET = 7'h72;
   localparam logic [6:0] SUBGROUP_THREE_RESET = 7'h74;
   localparam logic [6:0] BUS_RESET_CALL_ADDR = 7'h03;
   localparam logic [4:0] FIXED_ADDR_UPPER = 5'h18;
   localparam logic [6:0] FIXED_ADDR_EIGHT_PIN = 7'h62;
   localparam logic [3:0] BIT_COUNT_LAST = 4'h8;

   typedef struct packed {
      logic [6:0] broadcast_group_addr;
      logic [6:0] subgroup_addr_one;
      logic [6:0] subgroup_addr_two;
      logic [6:0] subgroup_addr_three;
      logic broadcast_enable;
      logic [2:0] subgroup_enable;
   } lda_addr_cfg_type;

   typedef struct packed {
      logic matched;
      logic read;
      logic regular;
      logic broadcast;
      logic [2:0] subgroup;
      logic bus_reset_call;
   } lda_match_type;
endpackage

/* File: design/lda_address_decode.sv */
// Slave address recognition for the LED driver serial bus interface
// Contract
// - Ten-pin part takes address from two straps; eight-pin part uses one fixed address.
// - Address byte bit 0 set means read, clear means write.
// - Broadcast address enabled at reset, default 1110 000, rewritable, volatile.
// - Sub-group addresses default 1110 001, 1110 010, 1110 100, rewritable.
// - Sub-group addresses disabled at reset and not acknowledged until enabled.
// - Reset call 0000 0110 acknowledged only with write direction.
// - Reserved values as own address are matched like any other.
// - Accepted reset call returns all settings to power-on defaults.
`timescale 1ns/1ps
module lda_address_decode
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ten_pin_variant,
   input wire logic addr_strap_0,
   input wire logic addr_strap_1,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire lda_pkg::lda_addr_cfg_type cfg_write_data,
   input wire logic cfg_write,
   output lda_pkg::lda_addr_cfg_type cfg_current,
   output lda_pkg::lda_match_type match_result,
   output logic match_valid,
   output logic bus_reset_pulse
);
   typedef enum logic [1:0] {LDA_IDLE = 2'b00, LDA_ADDR = 2'b01, LDA_ACK = 2'b11, LDA_DATA = 2'b10} lda_state_type;

   // Two-flop synchronisers on every pin input
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic [4:0] next_sync_a;
   logic scl;
   logic sda;
   logic scl_prev;
   logic sda_prev;
   logic strap_0;
   logic strap_1;
   logic variant;

   always_comb
   begin
      next_sync_a = {ten_pin_variant, addr_strap_1, addr_strap_0, sda_in, scl_in};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a <= 5'h1F;
         sync_b <= 5'h1F;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         sync_a <= next_sync_a;
         sync_b <= sync_a;
         scl_prev <= sync_b[0];
         sda_prev <= sync_b[1];
      end
   end

   assign scl = sync_b[0];
   assign sda = sync_b[1];
   assign strap_0 = sync_b[2];
   assign strap_1 = sync_b[3];
   assign variant = sync_b[4];

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   assign scl_rise = scl & ~scl_prev;
   assign scl_fall = ~scl & scl_prev;
   assign start_seen = scl & scl_prev & sda_prev & ~sda;
   assign stop_seen = scl & scl_prev & ~sda_prev & sda;

   function automatic lda_pkg::lda_match_type decode_addr(input logic [7:0] addr_byte,
      input logic [6:0] own_addr, input lda_pkg::lda_addr_cfg_type cfg);
      lda_pkg::lda_match_type m;
      m = '0;
      m.read = addr_byte[0];
      // Reserved values get no filtering on the own address
      m.regular = (addr_byte[7:1] == own_addr);
      m.broadcast = cfg.broadcast_enable && (addr_byte[7:1] == cfg.broadcast_group_addr);
      m.subgroup[0] = cfg.subgroup_enable[0] && (addr_byte[7:1] == cfg.subgroup_addr_one);
      m.subgroup[1] = cfg.subgroup_enable[1] && (addr_byte[7:1] == cfg.subgroup_addr_two);
      m.subgroup[2] = cfg.subgroup_enable[2] && (addr_byte[7:1] == cfg.subgroup_addr_three);
      m.bus_reset_call = (addr_byte[7:1] == lda_pkg::BUS_RESET_CALL_ADDR) && !addr_byte[0];
      m.matched = m.regular | m.broadcast | (|m.subgroup) | m.bus_reset_call;
      return m;
   endfunction

   // Own address: straps fill the two low bits on the ten-pin part
   logic [6:0] own_addr;
   assign own_addr = variant ? {lda_pkg::FIXED_ADDR_UPPER, strap_1, strap_0}
                             : lda_pkg::FIXED_ADDR_EIGHT_PIN;

   lda_pkg::lda_addr_cfg_type cfg;
   lda_pkg::lda_addr_cfg_type next_cfg;
   lda_state_type state;
   lda_state_type next_state;
   logic [3:0] bit_count;
   logic [3:0] next_bit_count;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic ack_drive;
   logic next_ack_drive;
   lda_pkg::lda_match_type result;
   lda_pkg::lda_match_type next_result;
   logic valid;
   logic next_valid;
   logic reset_pending;
   logic next_reset_pending;
   logic reset_pulse;
   logic next_reset_pulse;
   lda_pkg::lda_match_type found;

   localparam lda_pkg::lda_addr_cfg_type CFG_DEFAULT = '{
      broadcast_group_addr: lda_pkg::BROADCAST_ADDR_RESET,
      subgroup_addr_one: lda_pkg::SUBGROUP_ONE_RESET,
      subgroup_addr_two: lda_pkg::SUBGROUP_TWO_RESET,
      subgroup_addr_three: lda_pkg::SUBGROUP_THREE_RESET,
      broadcast_enable: 1'b1,
      subgroup_enable: 3'h0};

   always_comb
   begin
      found = decode_addr(shift, own_addr, cfg);
      next_state = state;
      next_bit_count = bit_count;
      next_shift = shift;
      next_ack_drive = ack_drive;
      next_result = result;
      next_valid = 1'b0;
      next_reset_pending = reset_pending;
      next_reset_pulse = 1'b0;
      next_cfg = cfg_write ? cfg_write_data : cfg;
      if (reset_pending && stop_seen)
      begin
         // Reset call takes effect at STOP, like power-on reset
         next_cfg = CFG_DEFAULT;
         next_reset_pending = 1'b0;
         next_reset_pulse = 1'b1;
      end
      if (start_seen)
      begin
         // First byte after any START is the address byte
         next_state = LDA_ADDR;
         next_bit_count = 4'h0;
         next_ack_drive = 1'b0;
         next_reset_pending = 1'b0;
      end
      else if (stop_seen)
      begin
         next_state = LDA_IDLE;
         next_ack_drive = 1'b0;
      end
      else
      begin
         unique case (state)
            LDA_IDLE:
            begin
            end
            LDA_ADDR:
            begin
               if (scl_rise)
               begin
                  next_shift = {shift[6:0], sda};
                  next_bit_count = bit_count + 4'h1;
               end
               else if (scl_fall && bit_count == lda_pkg::BIT_COUNT_LAST)
               begin
                  next_result = found;
                  next_valid = 1'b1;
                  next_ack_drive = found.matched;
                  next_reset_pending = found.bus_reset_call;
                  next_state = LDA_ACK;
               end
            end
            LDA_ACK:
            begin
               // Release after the ninth clock falls
               if (scl_fall)
               begin
                  next_ack_drive = 1'b0;
                  next_state = result.matched ? LDA_DATA : LDA_IDLE;
               end
            end
            LDA_DATA:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg <= CFG_DEFAULT;
         state <= LDA_IDLE;
         bit_count <= 4'h0;
         shift <= 8'h00;
         ack_drive <= 1'b0;
         result <= '0;
         valid <= 1'b0;
         reset_pending <= 1'b0;
         reset_pulse <= 1'b0;
      end
      else
      begin
         cfg <= next_cfg;
         state <= next_state;
         bit_count <= next_bit_count;
         shift <= next_shift;
         ack_drive <= next_ack_drive;
         result <= next_result;
         valid <= next_valid;
         reset_pending <= next_reset_pending;
         reset_pulse <= next_reset_pulse;
      end
   end

   // Open-drain: only ever pull low, enable low while driving
   assign sda_out = 1'b0;
   assign sda_oe_n = ~ack_drive;
   assign cfg_current = cfg;
   assign match_result = result;
   assign match_valid = valid;
   assign bus_reset_pulse = reset_pulse;
endmodule // lda_address_decode

/* File: sim/lda_chk.sv */
// Port checker for the address decoder
`timescale 1ns/1ps
module lda_chk
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sda_oe_n,
   input wire lda_pkg::lda_addr_cfg_type cfg_current,
   input wire lda_pkg::lda_match_type match_result,
   input wire logic match_valid,
   input wire logic bus_reset_pulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_ack; match_valid && match_result.matched |=> !sda_oe_n; endproperty
   a_ack: assert property (p_ack) else $error("match not acknowledged");
   property p_nack; match_valid && !match_result.matched |=> sda_oe_n; endproperty
   a_nack: assert property (p_nack) else $error("ack without match");
   // Decode strobe and acknowledge drive are registered on the same edge
   property p_cause; $fell(sda_oe_n) |-> match_valid; endproperty
   a_cause: assert property (p_cause) else $error("ack without decode");
   property p_sub; match_valid |-> (match_result.subgroup & ~cfg_current.subgroup_enable) == 3'h0; endproperty
   a_sub: assert property (p_sub) else $error("disabled subgroup matched");
   property p_bc; match_valid && match_result.broadcast |-> cfg_current.broadcast_enable; endproperty
   a_bc: assert property (p_bc) else $error("disabled broadcast matched");
   property p_rdir; match_valid && match_result.bus_reset_call |-> !match_result.read; endproperty
   a_rdir: assert property (p_rdir) else $error("reset call with read");
   property p_def; bus_reset_pulse |-> cfg_current == {7'h70, 7'h71, 7'h72, 7'h74, 4'h8}; endproperty
   a_def: assert property (p_def) else $error("defaults not restored");
   property p_one; match_valid |=> !match_valid; endproperty
   a_one: assert property (p_one) else $error("decode pulse too long");
endmodule // lda_chk
bind lda_address_decode lda_chk lda_chk_i (.clock(clock), .rst_n(rst_n), .sda_oe_n(sda_oe_n),
   .cfg_current(cfg_current), .match_result(match_result), .match_valid(match_valid),
   .bus_reset_pulse(bus_reset_pulse));

/* File: sim/lda_master.sv */
// Bus master model that sends one address byte per transfer
`timescale 1ns/1ps
module lda_master
(
   input wire logic clock,
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Open drain: a one releases the line, so the ninth bit lets the device answer
   task automatic xfer(input logic [7:0] b, input int q, output logic ack);
      logic [8:0] bits;
      bits = {b, 1'b1};
      sda = 1'b0;
      wt(q);
      for (int i = 8; i >= 0; i--)
      begin
         scl = 1'b0;
         sda = bits[i];
         wt(q);
         scl = 1'b1;
         wt(q);
      end
      ack = ~sda_line;
      scl = 1'b0;
      wt(q);
      sda = 1'b0;
      wt(q);
      scl = 1'b1;
      wt(q);
      sda = 1'b1;
      wt(q);
   endtask
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
endmodule // lda_master

/* File: sim/lda_address_decode_tb_top.sv */
// Self-checking bench for the address decoder
`timescale 1ns/1ps
module lda_address_decode_tb_top;
   localparam lda_pkg::lda_addr_cfg_type DEF = {7'h70, 7'h71, 7'h72, 7'h74, 4'h8};
   logic clock, rst_n, ten_pin_variant, addr_strap_0, addr_strap_1, scl, msda, sda_out, sda_oe_n;
   logic cfg_write, match_valid, bus_reset_pulse, ack, seen_rst;
   lda_pkg::lda_addr_cfg_type cfg_write_data, cfg_current;
   lda_pkg::lda_match_type match_result, last;
   int miscompares = 0;
   int compares = 0;
   wire sda_line = msda & (sda_oe_n | sda_out);
   lda_address_decode lda_address_decode_i (.clock(clock), .rst_n(rst_n), .ten_pin_variant(ten_pin_variant),
      .addr_strap_0(addr_strap_0), .addr_strap_1(addr_strap_1), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cfg_write_data(cfg_write_data), .cfg_write(cfg_write),
      .cfg_current(cfg_current), .match_result(match_result), .match_valid(match_valid),
      .bus_reset_pulse(bus_reset_pulse));
   lda_master lda_master_i (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(msda));
   always @(posedge clock)
   begin
      if (match_valid === 1'b1) last <= match_result;
      if (bus_reset_pulse === 1'b1) seen_rst <= 1'b1;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic stop_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic snd(input logic [7:0] b, input logic e, input int q);
      lda_master_i.xfer(b, q, ack);
      chk(ack, e);
      chk(last.matched, e);
      chk(last.read, b[0]);
   endtask
   task automatic t_defaults;
      logic [7:0] ad [12] = '{8'hC4, 8'hC5, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE8, 8'hE9, 8'h07, 8'h06};
      logic [11:0] ex = 12'b100000001111;
      chk(cfg_current, DEF);
      chk(sda_out, 1'b0);
      // E0h is sent only as the broadcast call, never as an ordinary address
      // Default sub-group values are probed only while they are disabled
      for (int i = 0; i < 12; i++)
         snd(ad[i], ex[i], 8);
      chk(seen_rst, 1'b1);
      $display("t_defaults done");
   endtask
   task automatic t_straps;
      ten_pin_variant = 1'b1;
      // Strapped addresses stay clear of broadcast, reset call and reserved values
      for (int s = 0; s < 4; s++)
      begin
         {addr_strap_1, addr_strap_0} = s[1:0];
         wt4();
         snd({5'h18, s[1:0], 1'b0}, 1'b1, 8);
         snd({5'h18, ~s[1:0], 1'b1}, 1'b0, 20);
      end
      ten_pin_variant = 1'b0;
      $display("t_straps done");
   endtask
   task automatic t_reset_call;
      // None of the new addresses is the reset call value
      cfg_write_data = {7'h11, 7'h21, 7'h31, 7'h41, 4'h7};
      cfg_write = 1'b1;
      wt4();
      cfg_write = 1'b0;
      chk(cfg_current, cfg_write_data);
      snd(8'hE0, 1'b0, 8);
      snd(8'h22, 1'b0, 8);
      snd(8'h42, 1'b1, 8);
      snd(8'h83, 1'b1, 8);
      seen_rst = 1'b0;
      snd(8'h07, 1'b0, 8);
      chk(seen_rst, 1'b0);
      snd(8'h06, 1'b1, 8);
      chk(seen_rst, 1'b1);
      chk(cfg_current, DEF);
      snd(8'h42, 1'b0, 8);
      snd(8'hE2, 1'b0, 8);
      snd(8'hE0, 1'b1, 8);
      $display("t_reset_call done");
   endtask
   task automatic wt4;
      repeat (4) @(posedge clock);
      #1;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      rst_n = 1'b0;
      ten_pin_variant = 1'b0;
      {addr_strap_1, addr_strap_0} = 2'h0;
      cfg_write = 1'b0;
      cfg_write_data = DEF;
      seen_rst = 1'b0;
      wt4();
      rst_n = 1'b1;
      wt4();
      t_defaults();
      t_straps();
      t_reset_call();
      stop_test();
   end
   // Some 30 transfers of 184 or 460 cycles each fit well inside this span
   initial
   begin
      #200000;
      miscompares++;
      stop_test();
   end
endmodule // lda_address_decode_tb_top
